// ### pkg/tx_stats_pkg.sv
/*
  Shared constants for the transmit statistics counter bank: counter width,
  byte lane layout and indirect byte addresses of the two counters.
  Assumes a byte-wide indirect register port with 16-bit byte addresses.
*/
package tx_stats_pkg;

  // Counter geometry
  localparam int CNT_W = 32;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 16;
  localparam int NUM_CNT = 2;
  localparam int LANE_W = 2;
  localparam logic [ADDR_W-1:0] CNT_BYTES = 16'h0004;

  // Counter slots in the bank
  localparam int VALID_BYTES_SLOT = 0;
  localparam int UNDERRUN_ABORT_SLOT = 1;

  // Indirect byte addresses of the most significant byte of each counter
  localparam logic [ADDR_W-1:0] TX_VALID_BYTES_COUNT_OFFSET = 16'h030c;
  localparam logic [ADDR_W-1:0] TX_UNDERRUN_ABORT_COUNT_OFFSET = 16'h0334;

  // Reset and wrap values
  localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 32'hffff_ffff;
  localparam logic [CNT_W-1:0] CNT_STEP = 32'h0000_0001;
  localparam logic [BYTE_W-1:0] UNMAPPED_DATA = 8'h00;

  // Lane 0 is the lowest address and carries the most significant byte
  localparam logic [LANE_W-1:0] MSB_LANE = 2'h0;

  function automatic logic [BYTE_W-1:0] byte_of(input logic [CNT_W-1:0] v,
                                                input logic [LANE_W-1:0] lane);
    logic [CNT_W-1:0] sh;
    sh = v >> (BYTE_W * (int'(CNT_BYTES) - 1 - int'(lane)));
    return sh[BYTE_W-1:0];
  endfunction

endpackage

// ### pkg/cnt_if.sv
/*
  Carrier between the counter bank and one statistics counter: the
  increment pulse and the live count. Assumes both ends share one clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface cnt_if;
  import tx_stats_pkg::*;
  logic inc;
  logic [CNT_W-1:0] value;
  modport counter (input inc, output value);
  modport user (output inc, input value);
endinterface
`default_nettype wire

// ### rtl/stat_counter.sv
/*
  One 32-bit statistics counter: adds one per increment pulse, wraps
  to zero, cleared only by reset. Assumes increment pulses are already
  synchronous to i_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module stat_counter
  import tx_stats_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Counter carrier
  cnt_if.counter cnt
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
  } cnt_state_s;

  cnt_state_s st;
  cnt_state_s next_st;

  always_comb begin
    next_st = st;
    if (cnt.inc) begin
      // Plain modulo add: rolls from the top value back to zero
      next_st.count = st.count + CNT_STEP;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      // Any increment seen during reset is dropped
      st.count <= CNT_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign cnt.value = st.count;

endmodule
`default_nettype wire

// ### rtl/mac_tx_statistics_counters.sv
/*
  Transmit statistics counter bank: valid bytes sent and frames aborted on
  transmit FIFO underrun, read through a byte-wide indirect port.
  Assumes increment pulses come from transmit logic on i_clk, one per event
  per cycle, and a register master that follows the single-cycle strobe
  protocol with read data one cycle after the read strobe.
*/
//
// Function
// - Count every valid transmitted byte in a 32-bit counter, one per byte.
// - Count every frame aborted by transmit FIFO underrun in a 32-bit counter.
// - Counters clear only on reset; reads never clear them.
// - Counters do not saturate; the top value wraps to zero.
// - Valid-bytes counter read at four byte addresses, MSB at lowest.
// - Underrun counter read at four byte addresses, MSB at lowest.
//
`timescale 1ns/100ps
`default_nettype none
module mac_tx_statistics_counters
  import tx_stats_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Transmit event pulses
  input wire logic i_tx_byte_ok,
  input wire logic i_tx_underrun_abort,
  // Register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [BYTE_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [BYTE_W-1:0] o_rdata
);

  typedef struct packed {
    logic [BYTE_W-1:0] rdata;
    logic [NUM_CNT-1:0][CNT_W-1:0] snap;
  } bank_state_s;

  bank_state_s st;
  bank_state_s next_st;

  logic [NUM_CNT-1:0][CNT_W-1:0] live;
  logic [NUM_CNT-1:0] hit;
  logic [NUM_CNT-1:0][LANE_W-1:0] lane;
  logic [NUM_CNT-1:0] inc;

  // Both counters are read-only; writes on the port have no effect
  logic unused_write;
  assign unused_write = i_wr ^ (^i_wdata);

  assign inc[VALID_BYTES_SLOT] = i_tx_byte_ok;
  assign inc[UNDERRUN_ABORT_SLOT] = i_tx_underrun_abort;

  cnt_if cnt [NUM_CNT] ();

  genvar g;
  generate
    for (g = 0; g < NUM_CNT; g++) begin : g_cnt
      localparam logic [ADDR_W-1:0] BASE =
        (g == VALID_BYTES_SLOT) ? TX_VALID_BYTES_COUNT_OFFSET
                                : TX_UNDERRUN_ABORT_COUNT_OFFSET;
      logic [ADDR_W-1:0] diff;

      assign cnt[g].inc = inc[g];
      assign live[g] = cnt[g].value;

      // Unsigned difference makes addresses below the base miss as well
      assign diff = i_addr - BASE;
      assign hit[g] = (diff < CNT_BYTES);
      assign lane[g] = diff[LANE_W-1:0];

      stat_counter u_counter (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .cnt(cnt[g])
      );
    end
  endgenerate

  // Reading the most significant byte captures the whole count, so the
  // three lower bytes read later belong to the same value even if the
  // counter moves in between. Trade-off: reading a lower byte without a
  // prior MSB read returns the last snapshot, not the live count.
  always_comb begin
    next_st = st;
    next_st.rdata = UNMAPPED_DATA;
    if (i_rd) begin
      for (int k = 0; k < NUM_CNT; k++) begin
        if (hit[k]) begin
          if (lane[k] == MSB_LANE) begin
            next_st.snap[k] = live[k];
            next_st.rdata = byte_of(live[k], MSB_LANE);
          end else begin
            next_st.rdata = byte_of(st.snap[k], lane[k]);
          end
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;

  // Checks
  logic [CNT_W-1:0] vb;
  logic [CNT_W-1:0] ua;
  logic [CNT_W-1:0] vb_snap;
  logic [CNT_W-1:0] ua_snap;
  assign vb = live[VALID_BYTES_SLOT];
  assign ua = live[UNDERRUN_ABORT_SLOT];
  assign vb_snap = st.snap[VALID_BYTES_SLOT];
  assign ua_snap = st.snap[UNDERRUN_ABORT_SLOT];

  valid_bytes_inc_a: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    i_tx_byte_ok |=> (vb == $past(vb) + CNT_STEP))
    else $error("valid bytes count did not step by one");

  underrun_inc_a: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    i_tx_underrun_abort |=> (ua == $past(ua) + CNT_STEP))
    else $error("underrun abort count did not step by one");

  read_no_clear_a: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    (!i_tx_byte_ok && !i_tx_underrun_abort)[*2] |=> $stable(vb) && $stable(ua))
    else $error("count changed without an increment");

  reset_zero_a: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    $rose(i_rstn) |-> (vb == CNT_RESET) && (ua == CNT_RESET))
    else $error("count not zero after reset");

  counter_wrap_a: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    (vb == CNT_MAX) && i_tx_byte_ok |=> (vb == CNT_RESET))
    else $error("valid bytes count did not wrap to zero");

  valid_msb_read_a: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    i_rd && (i_addr == TX_VALID_BYTES_COUNT_OFFSET)
      |=> (o_rdata == $past(vb[CNT_W-1 -: BYTE_W])) ##1 (o_rdata == UNMAPPED_DATA || $past(i_rd)))
    else $error("valid bytes MSB read returned wrong data");

  abort_lsb_read_a: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    i_rd && (i_addr == TX_UNDERRUN_ABORT_COUNT_OFFSET + CNT_BYTES - 16'h0001)
      |=> (o_rdata == $past(ua_snap[BYTE_W-1:0])))
    else $error("underrun LSB read returned wrong data");

  snapshot_hold_a: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    i_rd && (i_addr == TX_VALID_BYTES_COUNT_OFFSET)
      |=> (vb_snap == $past(vb)))
    else $error("MSB read did not capture a snapshot");

  // The full wrap needs 2^32 events; the byte carry is the reachable part of it
  byte_carry_a: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    (vb[BYTE_W-1:0] == CNT_MAX[BYTE_W-1:0]) && i_tx_byte_ok
      |=> (vb[BYTE_W-1:0] == CNT_RESET[BYTE_W-1:0])
        && (vb[CNT_W-1:BYTE_W] == $past(vb[CNT_W-1:BYTE_W]) + CNT_STEP[CNT_W-BYTE_W-1:0]))
    else $error("valid bytes count did not carry out of the low byte");

  abort_carry_a: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    (ua[BYTE_W-1:0] == CNT_MAX[BYTE_W-1:0]) && i_tx_underrun_abort
      |=> (ua[BYTE_W-1:0] == CNT_RESET[BYTE_W-1:0])
        && (ua[CNT_W-1:BYTE_W] == $past(ua[CNT_W-1:BYTE_W]) + CNT_STEP[CNT_W-BYTE_W-1:0]))
    else $error("underrun abort count did not carry out of the low byte");

  // Reset wins over any increment present in the same cycle
  reset_drop_a: assert property (
    @(posedge i_clk)
    !i_rstn |=> (vb == CNT_RESET) && (ua == CNT_RESET))
    else $error("count not cleared by reset");

  snap_steady_a: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    !(i_rd && (i_addr == TX_VALID_BYTES_COUNT_OFFSET))
      |=> $stable(vb_snap))
    else $error("valid bytes snapshot moved without an MSB read");

  abort_snap_a: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    i_rd && (i_addr == TX_UNDERRUN_ABORT_COUNT_OFFSET)
      |=> (ua_snap == $past(ua)))
    else $error("underrun MSB read did not capture a snapshot");

  abort_msb_read_a: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    i_rd && (i_addr == TX_UNDERRUN_ABORT_COUNT_OFFSET)
      |=> (o_rdata == $past(ua[CNT_W-1 -: BYTE_W])))
    else $error("underrun MSB read returned wrong data");

  abort_mid_read_a: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    i_rd && (i_addr == TX_UNDERRUN_ABORT_COUNT_OFFSET + 16'h0001)
      |=> (o_rdata == $past(ua_snap[CNT_W-BYTE_W-1 -: BYTE_W])))
    else $error("underrun second byte read returned wrong data");

  valid_mid_read_a: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    i_rd && (i_addr == TX_VALID_BYTES_COUNT_OFFSET + 16'h0002)
      |=> (o_rdata == $past(vb_snap[2*BYTE_W-1 -: BYTE_W])))
    else $error("valid bytes third byte read returned wrong data");

  valid_lsb_read_a: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    i_rd && (i_addr == TX_VALID_BYTES_COUNT_OFFSET + CNT_BYTES - 16'h0001)
      |=> (o_rdata == $past(vb_snap[BYTE_W-1:0])))
    else $error("valid bytes LSB read returned wrong data");

  // Read data stand for one cycle only, so an idle port shows the neutral byte
  idle_rdata_a: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    !i_rd |=> (o_rdata == UNMAPPED_DATA))
    else $error("read data present without a read");

  unmapped_read_a: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    i_rd && (i_addr == TX_VALID_BYTES_COUNT_OFFSET + CNT_BYTES)
      |=> (o_rdata == UNMAPPED_DATA))
    else $error("address past the counter returned data");

endmodule
`default_nettype wire

// ### test/mac_tx_statistics_counters_tb.sv
/*
  Self-checking bench for the transmit statistics counter bank.
  Assumes the single-cycle strobe register port and one shared clock.
*/
`timescale 1ns/100ps
`default_nettype none
module mac_tx_statistics_counters_tb;
  import tx_stats_pkg::*;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_tx_byte_ok = 1'b0;
  logic i_tx_underrun_abort = 1'b0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [BYTE_W-1:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [BYTE_W-1:0] o_rdata;
  int err_count = 0;
  int total_checks = 0;

  always #4 i_clk = ~i_clk;

  mac_tx_statistics_counters u_mac_tx_statistics_counters (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_tx_byte_ok(i_tx_byte_ok),
    .i_tx_underrun_abort(i_tx_underrun_abort), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));

  task automatic chk(input logic [BYTE_W-1:0] seen, input logic [BYTE_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Four back-to-back byte reads, most significant byte at the lowest address
  task automatic rd32(input logic [ADDR_W-1:0] base, input logic [CNT_W-1:0] exp);
    logic [CNT_W-1:0] sh;
    for (int i = 0; i < 5; i++) begin
      @(posedge i_clk);
      i_rd <= (i < 4);
      i_addr <= base + ADDR_W'(i);
      if (i > 0) begin
        #1;
        sh = exp >> (8 * (4 - i));
        chk(o_rdata, sh[7:0]);
      end
    end
  endtask

  // Same four reads, handing the assembled count back instead of judging it
  task automatic rd32_get(input logic [ADDR_W-1:0] base, output logic [CNT_W-1:0] got);
    got = '0;
    for (int i = 0; i < 5; i++) begin
      @(posedge i_clk);
      i_rd <= (i < 4);
      i_addr <= base + ADDR_W'(i);
      if (i > 0) begin
        #1;
        got = {got[CNT_W-BYTE_W-1:0], o_rdata};
      end
    end
  endtask

  task automatic pulse(input int n, input logic b, input logic u);
    @(posedge i_clk);
    i_tx_byte_ok <= b;
    i_tx_underrun_abort <= u;
    repeat (n - 1) @(posedge i_clk);
    @(posedge i_clk);
    i_tx_byte_ok <= 1'b0;
    i_tx_underrun_abort <= 1'b0;
  endtask

  task automatic t_reset_values();
    rd32(TX_VALID_BYTES_COUNT_OFFSET, 32'h0);
    rd32(TX_UNDERRUN_ABORT_COUNT_OFFSET, 32'h0);
    rd32(16'h0310, 32'h0);
    @(posedge i_clk);
    #1;
    chk(o_rdata, UNMAPPED_DATA);
    $display("test reset_values done");
  endtask

  // Counts above one byte catch swapped or misplaced byte lanes
  task automatic t_counting();
    pulse(258, 1'b1, 1'b1);
    pulse(1, 1'b0, 1'b1);
    rd32(TX_VALID_BYTES_COUNT_OFFSET, 32'h102);
    rd32(TX_UNDERRUN_ABORT_COUNT_OFFSET, 32'h103);
    rd32(TX_UNDERRUN_ABORT_COUNT_OFFSET, 32'h103);
    $display("test counting done");
  endtask

  task automatic t_write_ignored();
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= TX_VALID_BYTES_COUNT_OFFSET + 16'h3;
    i_wdata <= 8'hff;
    @(posedge i_clk);
    i_wr <= 1'b0;
    rd32(TX_VALID_BYTES_COUNT_OFFSET, 32'h102);
    $display("test write_ignored done");
  endtask

  // Counting goes on during the read; the bytes must all come from one capture
  task automatic t_snapshot();
    @(posedge i_clk);
    i_tx_byte_ok <= 1'b1;
    rd32(TX_VALID_BYTES_COUNT_OFFSET, 32'h103);
    @(posedge i_clk);
    i_tx_byte_ok <= 1'b0;
    rd32(TX_VALID_BYTES_COUNT_OFFSET, 32'h108);
    $display("test snapshot done");
  endtask

  // Measurement as software does it: start value, events, modular difference
  task automatic t_period();
    logic [CNT_W-1:0] start;
    logic [CNT_W-1:0] stop;
    rd32_get(TX_UNDERRUN_ABORT_COUNT_OFFSET, start);
    pulse(5, 1'b0, 1'b1);
    rd32_get(TX_UNDERRUN_ABORT_COUNT_OFFSET, stop);
    chk(BYTE_W'(stop - start), 8'h05);
    $display("test period done");
  endtask

  task automatic t_mid_reset();
    @(posedge i_clk);
    i_rstn <= 1'b0;
    i_tx_byte_ok <= 1'b1;
    i_tx_underrun_abort <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    i_tx_byte_ok <= 1'b0;
    i_tx_underrun_abort <= 1'b0;
    rd32(TX_VALID_BYTES_COUNT_OFFSET, 32'h0);
    rd32(TX_UNDERRUN_ABORT_COUNT_OFFSET, 32'h0);
    $display("test mid_reset done");
  endtask

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    t_reset_values();
    t_counting();
    t_write_ignored();
    t_snapshot();
    t_period();
    t_mid_reset();
    end_sim();
  end

  // Tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_clk);
    err_count++;
    end_sim();
  end
endmodule
`default_nettype wire
